// File: rtl/amb_cfg.svh
// timing and geometry constants for the async memory bus controller
`ifndef AMB_CFG_SVH
`define AMB_CFG_SVH
`define AMB_CLK_PERIOD_NS   10
`define AMB_NS2CYC(ns) (((ns) + `AMB_CLK_PERIOD_NS - 1) / `AMB_CLK_PERIOD_NS)
`define AMB_ADDR_W          20
`define AMB_DATA_W          16
`define AMB_CYCLE_MIN_NS    35
`define AMB_CYCLE_CYC       `AMB_NS2CYC(`AMB_CYCLE_MIN_NS)
`define AMB_ACCESS_MAX_NS   35
`define AMB_ACCESS_CYC      `AMB_NS2CYC(`AMB_ACCESS_MAX_NS)
`define AMB_WPULSE_MIN_NS   20
`define AMB_WPULSE_CYC      `AMB_NS2CYC(`AMB_WPULSE_MIN_NS)
`define AMB_RECOV_MIN_NS    12
`define AMB_RECOV_CYC       `AMB_NS2CYC(`AMB_RECOV_MIN_NS)
`define AMB_RELEASE_MAX_NS  15
`define AMB_RELEASE_CYC     `AMB_NS2CYC(`AMB_RELEASE_MAX_NS)
`define AMB_STARTUP_NS      2000000
`define AMB_STARTUP_CYC     (`AMB_STARTUP_NS / `AMB_CLK_PERIOD_NS)
`endif

// File: rtl/amb_pkg.sv
// types for the async memory bus controller
package amb_pkg;
  typedef enum logic [5:0] {
    AMB_ST_START = 6'h01,
    AMB_ST_IDLE  = 6'h02,
    AMB_ST_READ  = 6'h04,
    AMB_ST_WRITE = 6'h08,
    AMB_ST_RECOV = 6'h10,
    AMB_ST_GAP   = 6'h20
  } amb_state_e;
endpackage : amb_pkg

// File: rtl/amb_timer.sv
// down counter used for phase timing
module amb_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         reset_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  // status
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          zero = (cnt_q == '0);
  assign cnt_d = load ? value : (zero ? cnt_q : cnt_q - 1'b1);
  assign done  = zero;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule : amb_timer

// File: rtl/amb_host.sv
// host controller driving the async nonvolatile memory bus
`include "amb_cfg.svh"
module amb_host import amb_pkg::*; #(
  parameter int STARTUP_CYC = `AMB_STARTUP_CYC,
  parameter int AW          = `AMB_ADDR_W,
  parameter int DW          = `AMB_DATA_W
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          reset_n,
  // user request
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic [1:0]    req_lanes,
  output logic               req_ready,
  // user answer
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  // memory pins
  output logic [AW-1:0]      mem_addr,
  output logic               mem_sel_n,
  output logic               mem_wstb_n,
  output logic               mem_oe_n,
  output logic               high_lane_sel_n,
  output logic               low_lane_sel_n,
  input  wire logic [DW-1:0] mem_dq_in,
  output logic [DW-1:0]      mem_dq_out,
  output logic               mem_dq_oe
);
  localparam int TW = 24;
  amb_state_e    st_q, st_d;
  logic [TW-1:0] tval;
  logic          tload;
  logic          tdone;
  logic          wr_q;
  logic [1:0]    lanes_q;
  logic          boot_q;

  amb_timer #(.W(TW)) u_timer (
    .clock   (clock),
    .reset_n (reset_n),
    .load    (tload),
    .value   (tval),
    .done    (tdone)
  );

  wire take = (st_q == AMB_ST_IDLE) && req_valid;
  wire [TW-1:0] startup_v = TW'(STARTUP_CYC);
  wire [TW-1:0] access_v  = TW'(`AMB_ACCESS_CYC - 1);
  wire [TW-1:0] wpulse_v  = TW'(`AMB_WPULSE_CYC - 1);
  wire [TW-1:0] recov_v   = TW'(`AMB_RECOV_CYC - 1);
  wire [TW-1:0] release_v = TW'(`AMB_RELEASE_CYC - 1);

  // next state and timer loads
  always_comb begin
    st_d  = st_q;
    tload = 1'b0;
    tval  = '0;
    case (st_q)
      AMB_ST_START: begin
        if (boot_q) begin
          tload = 1'b1;
          tval  = startup_v;
        end else if (tdone) begin
          st_d = AMB_ST_IDLE;
        end
      end
      AMB_ST_IDLE: if (take) begin
        st_d  = req_write ? AMB_ST_WRITE : AMB_ST_READ;
        tload = 1'b1;
        tval  = req_write ? wpulse_v : access_v;
      end
      AMB_ST_READ: if (tdone) begin
        st_d  = AMB_ST_GAP;
        tload = 1'b1;
        tval  = release_v;
      end
      AMB_ST_WRITE: if (tdone) begin
        st_d  = AMB_ST_RECOV;
        tload = 1'b1;
        tval  = recov_v;
      end
      AMB_ST_RECOV: if (tdone) st_d = AMB_ST_IDLE;
      AMB_ST_GAP: if (tdone) st_d = AMB_ST_IDLE;
      default: st_d = AMB_ST_IDLE;
    endcase
  end

  wire in_cyc = (st_d == AMB_ST_READ) || (st_d == AMB_ST_WRITE);
  wire wr_d   = take ? req_write : wr_q;
  wire [1:0] ln_d = take ? req_lanes : lanes_q;
  wire rd_done = (st_q == AMB_ST_READ) && tdone;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= AMB_ST_START;
    end else if (st_q == AMB_ST_START && !tdone) begin
      st_q <= st_q;
    end else begin
      st_q <= st_d;
    end
  end

  // boot_q marks the first cycle after reset release, in which the
  // startup wait is loaded into the timer; a later reset reloads it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) boot_q <= 1'b1;
    else boot_q <= 1'b0;
  end

  // next values of the pin and handshake flops
  wire            sel_n_d   = !in_cyc;
  wire            wstb_n_d  = !(in_cyc && wr_d);
  wire            oe_n_d    = !(in_cyc && !wr_d);
  wire            hi_n_d    = !(in_cyc && ln_d[1]);
  wire            lo_n_d    = !(in_cyc && ln_d[0]);
  wire            in_gap    = (st_q == AMB_ST_GAP);
  wire            dq_oe_d   = in_cyc && wr_d && !in_gap;
  wire            wr_done   = (st_q == AMB_ST_WRITE) && tdone;
  wire            ready_d   = (st_d == AMB_ST_IDLE) && !take;
  wire            rsp_d     = rd_done || wr_done;
  // disabled lanes read back as zero
  wire [DW/2-1:0] hi_byte_d = ln_d[1] ? mem_dq_in[DW-1:DW/2] : '0;
  wire [DW/2-1:0] lo_byte_d = ln_d[0] ? mem_dq_in[DW/2-1:0] : '0;
  wire [DW-1:0]   rdata_d   = {hi_byte_d, lo_byte_d};

  // request kind and lanes held for the whole cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q    <= 1'b0;
      lanes_q <= 2'h0;
    end else begin
      wr_q    <= wr_d;
      lanes_q <= ln_d;
    end
  end

  // address and write data latch on take and stand until the next one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr   <= '0;
      mem_dq_out <= '0;
    end else if (take) begin
      mem_addr   <= req_addr;
      mem_dq_out <= req_wdata;
    end
  end

  // select and strobe rise on one edge, so the write ends cleanly
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_sel_n  <= 1'b1;
      mem_wstb_n <= 1'b1;
    end else begin
      mem_sel_n  <= sel_n_d;
      mem_wstb_n <= wstb_n_d;
    end
  end

  // output enable only in read cycles
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_oe_n <= 1'b1;
    end else begin
      mem_oe_n <= oe_n_d;
    end
  end

  // both lane enables switch on one edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      high_lane_sel_n <= 1'b1;
      low_lane_sel_n  <= 1'b1;
    end else begin
      high_lane_sel_n <= hi_n_d;
      low_lane_sel_n  <= lo_n_d;
    end
  end

  // host drives data only while the write strobe is low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_dq_oe <= 1'b0;
    end else begin
      mem_dq_oe <= dq_oe_d;
    end
  end

  // handshake towards the user
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      req_ready <= ready_d;
      rsp_valid <= rsp_d;
    end
  end

  // read data taken once the access time has run out
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsp_rdata <= '0;
    end else if (rd_done) begin
      rsp_rdata <= rdata_d;
    end
  end
endmodule : amb_host

// File: bench/amb_mem_model.sv
// behavioural model of the asynchronous memory device
module amb_mem_model (
  // clock
  input  wire logic        clock,
  // control pins
  input  wire logic        sel_n,
  input  wire logic        wstb_n,
  input  wire logic        oe_n,
  input  wire logic        hi_n,
  input  wire logic        lo_n,
  // address and data
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_o,
  output logic      [15:0] dq_i
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] w;
  logic [15:0] rw;
  logic        t_q = 1'b0;
  always @(posedge clock) begin
    if (!sel_n && !wstb_n) begin
      w = mem.exists(addr) ? mem[addr] : 16'h0000;
      if (!hi_n) w[15:8] = dq_o[15:8];
      if (!lo_n) w[7:0] = dq_o[7:0];
      mem[addr] = w;
    end
  end
  // drive settles half a cycle after the pins move; idle lanes toggle
  always @(negedge clock) begin
    t_q = ~t_q;
    rw = mem.exists(addr) ? mem[addr] : 16'h0000;
    dq_i = {16{t_q}};
    if (!sel_n && !oe_n && wstb_n) begin
      if (!hi_n) dq_i[15:8] = rw[15:8];
      if (!lo_n) dq_i[7:0] = rw[7:0];
    end
  end
endmodule : amb_mem_model

// File: bench/amb_host_asserts.sv
// timing checks on the host controller pins
module amb_host_asserts (
  // clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // user side
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [1:0]  req_lanes,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  // memory pins
  input wire logic [19:0] mem_addr,
  input wire logic        mem_sel_n,
  input wire logic        mem_wstb_n,
  input wire logic        mem_oe_n,
  input wire logic        high_lane_sel_n,
  input wire logic        low_lane_sel_n,
  input wire logic        mem_dq_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_sel_gap: assert property (
    $fell(mem_sel_n) |=> (!$fell(mem_sel_n)) [*3]) else $error("sel gap");
  a_read_quiet: assert property (
    !mem_oe_n |-> mem_wstb_n && !mem_dq_oe) else $error("read drive");
  a_write_pins: assert property (
    !mem_wstb_n |-> mem_oe_n && !mem_sel_n && mem_dq_oe) else $error("wr");
  a_write_end: assert property (
    $rose(mem_wstb_n) |-> $rose(mem_sel_n)) else $error("write end");
  a_write_pulse: assert property (
    $fell(mem_wstb_n) |=> !mem_wstb_n) else $error("short pulse");
  a_addr_hold: assert property (
    $rose(mem_wstb_n) |=> $stable(mem_addr)) else $error("addr hold");
  a_lane_map: assert property (req_valid && req_ready |=>
    {high_lane_sel_n, low_lane_sel_n} == ~$past(req_lanes)) else $error("ln");
  a_read_lat: assert property (
    req_valid && req_ready && !req_write |-> ##5 rsp_valid) else $error("rl");
endmodule : amb_host_asserts

bind amb_host amb_host_asserts u_chk (.*);

// File: bench/amb_host_tb_top.sv
// self-checking bench for the memory bus host controller
module amb_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write;
  logic [19:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_rdata, mem_dq_in, mem_dq_out, r;
  logic [1:0]  req_lanes;
  logic        req_ready, rsp_valid, mem_sel_n, mem_wstb_n, mem_oe_n;
  logic        high_lane_sel_n, low_lane_sel_n, mem_dq_oe;
  int          failures = 0, n_tests = 0;
  always #5 clock = ~clock;
  amb_host #(.STARTUP_CYC(5)) dut (.*);
  amb_mem_model u_mem (.clock(clock), .sel_n(mem_sel_n), .wstb_n(mem_wstb_n),
    .oe_n(mem_oe_n), .hi_n(high_lane_sel_n), .lo_n(low_lane_sel_n),
    .addr(mem_addr), .dq_o(mem_dq_out), .dq_i(mem_dq_in));
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // hold the request until taken, then time the answer
  task automatic op(logic w, logic [19:0] a, logic [15:0] d, logic [1:0] l);
    int  n;
    logic t;
    {req_valid, req_write, req_addr} = {1'b1, w, a};
    {req_wdata, req_lanes} = {d, l};
    n = 0;
    t = 1'b0;
    while (!t && n < 99) begin
      t = (req_ready === 1'b1);
      @(posedge clock) #1;
      n++;
    end
    req_valid = 1'b0;
    n = t ? 1 : 99;
    while (rsp_valid !== 1'b1 && n < 99) begin
      @(posedge clock) #1;
      n++;
    end
    chk("no timeout", 16'(n < 99), 16'h0001);
    if (n < 99) chk("latency", 16'(n), w ? 16'h0003 : 16'h0005);
    r = rsp_rdata;
  endtask : op
  task automatic t_start();
    int   n;
    logic lo;
    lo = 1'b0;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
      lo = lo | (mem_sel_n !== 1'b1) | (mem_wstb_n !== 1'b1);
      @(posedge clock) #1;
    end
    chk("startup", 16'(n >= 5 && n < 40), 16'h0001);
    chk("ctl idle", 16'(lo), 16'h0000);
    chk("sel idle", 16'(mem_sel_n), 16'h0001);
    $display("startup test done");
  endtask : t_start
  task automatic t_rw();
    op(1'b1, 20'hFFFFF, 16'hA5C3, 2'h3);
    op(1'b1, 20'h00000, 16'h5A3C, 2'h3);
    op(1'b0, 20'hFFFFF, 16'h0000, 2'h3);
    chk("read top", r, 16'hA5C3);
    op(1'b0, 20'h00000, 16'h0000, 2'h3);
    chk("read bottom", r, 16'h5A3C);
    $display("write read test done");
  endtask : t_rw
  task automatic t_lane();
    op(1'b1, 20'hFFFFF, 16'h1234, 2'h2);
    op(1'b1, 20'hFFFFF, 16'hFFFF, 2'h0);
    op(1'b0, 20'hFFFFF, 16'h0000, 2'h3);
    chk("upper lane", r, 16'h12C3);
    op(1'b0, 20'hFFFFF, 16'h0000, 2'h1);
    chk("lower only", r, 16'h00C3);
    $display("lane test done");
  endtask : t_lane
  initial begin
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    t_start();
    t_rw();
    t_lane();
    results();
  end
endmodule : amb_host_tb_top
